// ==== verilog/wtcr_pkg.sv ====
package wtcr_pkg;

    // ---------------------------------------------------------------
    // Register addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_FIRST_MSB = 8'h00;
    localparam logic [7:0] ADDR_CONVERSION_ON_READ_SELECT_LAST = 8'h05;
    localparam logic [7:0] ADDR_STATUS = 8'h06;
    localparam logic [7:0] ADDR_COVER_FIRST = 8'h07;
    localparam logic [7:0] ADDR_WAKE_CTRL = 8'h0D;
    localparam logic [7:0] ADDR_Z_LIMITS = 8'h0F;
    localparam logic [7:0] ADDR_CONFIG = 8'h10;
    localparam logic [7:0] ADDR_CONFIG2 = 8'h14;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] Z_LIMITS_RST = 8'h38;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [11:0] RESULT_RST = 12'h000;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CFG_TEMP_DIS = 7;
    localparam int CFG_PLANAR = 6;
    localparam int CFG_CONVERSION_ON_READ_SELECT_HI = 5;
    localparam int CFG_CONVERSION_ON_READ_SELECT_LO = 4;
    localparam int CFG_DOUBLE = 3;
    localparam int CFG_TC_HI = 2;
    localparam int CFG_TC_LO = 1;
    localparam int CFG_PARITY = 0;
    localparam int ZL_UP_HI = 5;
    localparam int ZL_UP_LO = 3;
    localparam int ZL_LO_HI = 2;
    localparam int ZL_LO_LO = 0;
    localparam int ZL_COVER_HI = 5;
    localparam int WAKE_EN_BIT = 6;
    localparam int STATUS_CF_BIT = 4;
    localparam int CFG2_QUAD_BIT = 0;

    localparam logic [1:0] CONVERSION_ON_READ_SELECT_BEFORE_MSB = 2'h1;
    localparam logic [1:0] INTEG_NORMAL = 2'h0;
    localparam logic [1:0] INTEG_DOUBLE = 2'h1;
    localparam logic [1:0] INTEG_QUAD = 2'h2;
    localparam logic [1:0] CH_TEMP = 2'h3;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_FIELD_CONV_NS = 2000;
    localparam int T_TEMP_CONV_NS = 3000;
    localparam int FIELD_CYC = (T_FIELD_CONV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TEMP_CYC = (T_TEMP_CONV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic {WTCR_IDLE, WTCR_CONV} wtcr_seq_e;

endpackage

// ==== verilog/wtcr_cfg_if.sv ====
`timescale 1ns/10ps
interface wtcr_cfg_if;
    logic start;
    logic temp_enable;
    logic z_enable;
    logic double_sens;
    logic quad_sens;
    logic busy;

    modport ctrl (output start, output temp_enable, output z_enable, output double_sens, output quad_sens,
                  input busy);
    modport seq (input start, input temp_enable, input z_enable, input double_sens, input quad_sens,
                 output busy);
endinterface

// ==== verilog/wtcr_conv_seq.sv ====
`timescale 1ns/10ps
module wtcr_conv_seq (
    input wire logic clk_sys_i, // System clock
    input wire logic arst_n_i, // Async reset, active low
    wtcr_cfg_if.seq cfg, // Channel setup and start
    input wire logic [11:0] adc_data_i, // Converter result
    output logic [1:0] adc_channel_o, // Channel being converted
    output logic [1:0] adc_integ_sel_o, // Integration length
    output logic [3:0][11:0] results_o // X, Y, Z, temperature
);

    wtcr_pkg::wtcr_seq_e state_reg;
    logic [1:0] ch_reg;
    logic [3:0] mask_reg;
    logic [11:0] cnt_reg;
    logic [3:0] mask_next;
    logic [2:0] first_ch;
    logic [2:0] next_ch;

    // Lowest enabled channel above the given one; bit 2 marks none found
    function automatic logic [2:0] find_after(input logic [3:0] mask, input int from);
        logic [2:0] res;
        res = 3'h4;
        for (int i = 3; i >= 0; i--)
        begin
            if (mask[i] && i > from)
            begin
                res = 3'(i);
            end
        end
        return res;
    endfunction

    function automatic logic [11:0] conv_cycles(input logic [1:0] ch, input logic dbl, input logic quad);
        logic [11:0] res;
        res = 12'(wtcr_pkg::FIELD_CYC);
        if (ch == wtcr_pkg::CH_TEMP)
        begin
            res = 12'(wtcr_pkg::TEMP_CYC);
        end
        else if (dbl && quad)
        begin
            res = 12'(wtcr_pkg::FIELD_CYC * 4);
        end
        else if (dbl)
        begin
            res = 12'(wtcr_pkg::FIELD_CYC * 2);
        end
        return res;
    endfunction

    function automatic logic [1:0] integ_of(input logic [1:0] ch, input logic dbl, input logic quad);
        logic [1:0] res;
        res = wtcr_pkg::INTEG_NORMAL;
        if (ch != wtcr_pkg::CH_TEMP && dbl)
        begin
            res = quad ? wtcr_pkg::INTEG_QUAD : wtcr_pkg::INTEG_DOUBLE;
        end
        return res;
    endfunction

    assign mask_next = {cfg.temp_enable, cfg.z_enable, 2'b11};
    assign first_ch = find_after(mask_next, -1);
    assign next_ch = find_after(mask_reg, int'(ch_reg));

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    // integration per channel
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_reg <= wtcr_pkg::WTCR_IDLE;
            ch_reg <= 2'h0;
            mask_reg <= 4'h0;
            cnt_reg <= 12'h000;
            cfg.busy <= 1'b0;
            adc_integ_sel_o <= wtcr_pkg::INTEG_NORMAL;
        end
        else
        begin
            case (state_reg)
                wtcr_pkg::WTCR_IDLE:
                begin
                    if (cfg.start)
                    begin
                        state_reg <= wtcr_pkg::WTCR_CONV;
                        mask_reg <= mask_next;
                        ch_reg <= first_ch[1:0];
                        cnt_reg <= conv_cycles(first_ch[1:0], cfg.double_sens, cfg.quad_sens) - 12'h001;
                        adc_integ_sel_o <= integ_of(first_ch[1:0], cfg.double_sens, cfg.quad_sens);
                        cfg.busy <= 1'b1;
                    end
                end
                wtcr_pkg::WTCR_CONV:
                begin
                    if (cnt_reg != 12'h000)
                    begin
                        cnt_reg <= cnt_reg - 12'h001;
                    end
                    else if (!next_ch[2])
                    begin
                        ch_reg <= next_ch[1:0];
                        cnt_reg <= conv_cycles(next_ch[1:0], cfg.double_sens, cfg.quad_sens) - 12'h001;
                        adc_integ_sel_o <= integ_of(next_ch[1:0], cfg.double_sens, cfg.quad_sens);
                    end
                    else
                    begin
                        state_reg <= wtcr_pkg::WTCR_IDLE;
                        cfg.busy <= 1'b0;
                    end
                end
                default:
                begin
                    state_reg <= wtcr_pkg::WTCR_IDLE;
                end
            endcase
        end
    end

    assign adc_channel_o = ch_reg;

    // ---------------------------------------------------------------
    // Result holding
    // ---------------------------------------------------------------
    for (genvar g = 0; g < 4; g++)
    begin : g_result
        always_ff @(posedge clk_sys_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                results_o[g] <= wtcr_pkg::RESULT_RST;
            end
            else if (state_reg == wtcr_pkg::WTCR_IDLE && cfg.start && !mask_next[g])
            begin
                results_o[g] <= wtcr_pkg::RESULT_RST;
            end
            else if (state_reg == wtcr_pkg::WTCR_CONV && cnt_reg == 12'h000 && ch_reg == 2'(g))
            begin
                results_o[g] <= adc_data_i;
            end
        end
    end

    a_temp_integ_fixed: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (state_reg == wtcr_pkg::WTCR_CONV && ch_reg == wtcr_pkg::CH_TEMP)
        |-> adc_integ_sel_o == wtcr_pkg::INTEG_NORMAL)
        else $error("temperature conversion uses a longer integration");

endmodule // wtcr_conv_seq

// ==== verilog/wtcr_regs.sv ====
// Behaviour
// - Z limits register: upper in 5:3, lower in 2:0, reset value 38.
// - Temp-disable 0 converts temperature; 1 converts fields only, temp result held at reset.
// - Planar-only with temp disabled skips Z; Z and temp results stay at reset.
// - Single-byte read: trigger 00 none, 01 before first MSB, 1x after register 05.
// - Two-byte read protocol ignores the trigger field.
// - Short-range bit doubles field sensitivity through longer integration.
// - Coefficient field 2:1 selects compensation curve 0 to 3.
// - Odd parity over registers 07 to 10, config bit 0 as parity bit.
// - After reset parity counts as failing and the parity-ok flag is clear.
// - A write leaving parity wrong disables the low-power monitor.
// - Enabled monitor asserts interrupt at or above upper, at or below lower.
// - Monitor enable accepted only with odd parity and parity-ok flag set.
// - Quad bit set only when double bit already set; clearing always allowed.
`timescale 1ns/10ps
module wtcr_regs (
    input wire logic clk_sys_i, // System clock, 200 MHz
    input wire logic arst_n_i, // Async reset, active low
    input wire logic [7:0] reg_addr_i, // Register address from the serial front end
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic reg_wr_i, // Write strobe, one cycle
    input wire logic reg_rd_i, // Read strobe, one cycle
    output logic [7:0] reg_rdata_o, // Read data, valid the cycle after reg_rd_i
    input wire logic single_byte_read_select_i, // One-byte read protocol selected
    input wire logic wake_regs_parity_i, // XOR of covered bits of registers 07 to 0E
    input wire logic meas_valid_i, // New Z measurement, one cycle
    input wire logic [11:0] z_meas_i, // Z measurement, signed
    input wire logic [8:0] z_upper_msb_i, // Upper threshold high bits
    input wire logic [8:0] z_lower_msb_i, // Lower threshold high bits
    input wire logic [11:0] adc_data_i, // Converter result
    output logic [1:0] adc_channel_o, // Channel being converted
    output logic [1:0] adc_integ_sel_o, // Integration length
    output logic [3:0][11:0] conv_results_o, // X, Y, Z, temperature results
    output logic conv_busy_o, // Conversion running
    output logic [1:0] field_temp_coefficient_select_o, // Compensation curve
    output logic config_parity_ok_flag_o, // Parity-ok flag
    output logic low_power_monitor_enable_o, // Monitor enabled
    output logic int_n_o // Interrupt, active low
);

    logic [7:0] z_limits_reg;
    logic [7:0] sensor_config_reg;
    logic quad_sensitivity_reg;
    logic check_pending_reg;
    logic conv_start_reg;
    logic parity_odd;
    logic [1:0] conversion_on_read_select;
    logic signed [11:0] upper_thr;
    logic signed [11:0] lower_thr;
    logic in_alarm;
    logic wake_req;
    logic wake_accept;

    wtcr_cfg_if cfg_bus ();

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    // Z limits storage
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            z_limits_reg <= wtcr_pkg::Z_LIMITS_RST;
        end
        else if (reg_wr_i && hit(reg_addr_i, wtcr_pkg::ADDR_Z_LIMITS))
        begin
            z_limits_reg <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sensor_config_reg <= wtcr_pkg::CONFIG_RST;
        end
        else if (reg_wr_i && hit(reg_addr_i, wtcr_pkg::ADDR_CONFIG))
        begin
            sensor_config_reg <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            quad_sensitivity_reg <= 1'b0;
        end
        else if (reg_wr_i && hit(reg_addr_i, wtcr_pkg::ADDR_CONFIG2))
        begin
            if (!reg_wdata_i[wtcr_pkg::CFG2_QUAD_BIT] || sensor_config_reg[wtcr_pkg::CFG_DOUBLE])
            begin
                quad_sensitivity_reg <= reg_wdata_i[wtcr_pkg::CFG2_QUAD_BIT];
            end
        end
    end

    assign field_temp_coefficient_select_o = sensor_config_reg[wtcr_pkg::CFG_TC_HI:wtcr_pkg::CFG_TC_LO];

    // ---------------------------------------------------------------
    // Parity and monitor enable
    // ---------------------------------------------------------------
    // odd parity over covered bits
    assign parity_odd = ^{wake_regs_parity_i, z_limits_reg[wtcr_pkg::ZL_COVER_HI:0], sensor_config_reg};

    // Check runs the cycle after any write to a covered register
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            check_pending_reg <= 1'b0;
        end
        else
        begin
            check_pending_reg <= reg_wr_i && reg_addr_i >= wtcr_pkg::ADDR_COVER_FIRST
                && reg_addr_i <= wtcr_pkg::ADDR_CONFIG;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            config_parity_ok_flag_o <= 1'b0;
        end
        else if (check_pending_reg)
        begin
            config_parity_ok_flag_o <= parity_odd;
        end
    end

    assign wake_req = reg_wr_i && hit(reg_addr_i, wtcr_pkg::ADDR_WAKE_CTRL);
    assign wake_accept = wake_req && reg_wdata_i[wtcr_pkg::WAKE_EN_BIT] && parity_odd && config_parity_ok_flag_o;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            low_power_monitor_enable_o <= 1'b0;
        end
        else if (wake_accept)
        begin
            low_power_monitor_enable_o <= 1'b1;
        end
        else if ((check_pending_reg && !parity_odd) || (wake_req && !reg_wdata_i[wtcr_pkg::WAKE_EN_BIT]))
        begin
            low_power_monitor_enable_o <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Threshold interrupt
    // ---------------------------------------------------------------
    assign upper_thr = $signed({z_upper_msb_i, z_limits_reg[wtcr_pkg::ZL_UP_HI:wtcr_pkg::ZL_UP_LO]});
    assign lower_thr = $signed({z_lower_msb_i, z_limits_reg[wtcr_pkg::ZL_LO_HI:wtcr_pkg::ZL_LO_LO]});
    assign in_alarm = $signed(z_meas_i) >= upper_thr || $signed(z_meas_i) <= lower_thr;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            int_n_o <= 1'b1;
        end
        else if (!low_power_monitor_enable_o)
        begin
            int_n_o <= 1'b1;
        end
        else if (meas_valid_i)
        begin
            int_n_o <= !in_alarm;
        end
    end

    // ---------------------------------------------------------------
    // Conversion trigger on read
    // ---------------------------------------------------------------
    assign conversion_on_read_select = sensor_config_reg[wtcr_pkg::CFG_CONVERSION_ON_READ_SELECT_HI:wtcr_pkg::CFG_CONVERSION_ON_READ_SELECT_LO];

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            conv_start_reg <= 1'b0;
        end
        else
        begin
            conv_start_reg <= reg_rd_i && single_byte_read_select_i
                && ((conversion_on_read_select == wtcr_pkg::CONVERSION_ON_READ_SELECT_BEFORE_MSB
                     && hit(reg_addr_i, wtcr_pkg::ADDR_FIRST_MSB))
                    || (conversion_on_read_select[1] && hit(reg_addr_i, wtcr_pkg::ADDR_CONVERSION_ON_READ_SELECT_LAST)));
        end
    end

    // ---------------------------------------------------------------
    // Conversion sequencer
    // ---------------------------------------------------------------
    assign cfg_bus.start = conv_start_reg;
    assign cfg_bus.temp_enable = !sensor_config_reg[wtcr_pkg::CFG_TEMP_DIS];
    // Z skipped only with temperature off
    assign cfg_bus.z_enable = !(sensor_config_reg[wtcr_pkg::CFG_PLANAR] && sensor_config_reg[wtcr_pkg::CFG_TEMP_DIS]);
    assign cfg_bus.double_sens = sensor_config_reg[wtcr_pkg::CFG_DOUBLE];
    assign cfg_bus.quad_sens = quad_sensitivity_reg;
    assign conv_busy_o = cfg_bus.busy;

    wtcr_conv_seq u_seq (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .cfg(cfg_bus),
        .adc_data_i(adc_data_i),
        .adc_channel_o(adc_channel_o),
        .adc_integ_sel_o(adc_integ_sel_o),
        .results_o(conv_results_o)
    );

    // ---------------------------------------------------------------
    // Read back
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                wtcr_pkg::ADDR_STATUS: reg_rdata_o <= 8'(config_parity_ok_flag_o) << wtcr_pkg::STATUS_CF_BIT;
                wtcr_pkg::ADDR_WAKE_CTRL: reg_rdata_o <= 8'(low_power_monitor_enable_o) << wtcr_pkg::WAKE_EN_BIT;
                wtcr_pkg::ADDR_Z_LIMITS: reg_rdata_o <= z_limits_reg;
                wtcr_pkg::ADDR_CONFIG: reg_rdata_o <= sensor_config_reg;
                wtcr_pkg::ADDR_CONFIG2: reg_rdata_o <= 8'(quad_sensitivity_reg) << wtcr_pkg::CFG2_QUAD_BIT;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_zlim_write_store: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == wtcr_pkg::ADDR_Z_LIMITS |=> z_limits_reg == $past(reg_wdata_i))
        else $error("Z limits write not stored");

    a_temp_skip_start: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        conv_start_reg && !conv_busy_o && sensor_config_reg[wtcr_pkg::CFG_TEMP_DIS]
        |=> conv_results_o[3] == wtcr_pkg::RESULT_RST)
        else $error("temperature result not held at reset value");

    a_planar_z_skip: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        conv_busy_o && sensor_config_reg[wtcr_pkg::CFG_PLANAR] && sensor_config_reg[wtcr_pkg::CFG_TEMP_DIS]
        && $stable(sensor_config_reg) && $past(conv_start_reg) |-> conv_results_o[2] == wtcr_pkg::RESULT_RST)
        else $error("Z result changed in planar mode");

    a_conversion_on_read_select_ignored_two: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        reg_rd_i && !single_byte_read_select_i |=> !conv_start_reg)
        else $error("conversion triggered under two-byte protocol");

    a_conversion_on_read_select_before_msb: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        reg_rd_i && single_byte_read_select_i && reg_addr_i == wtcr_pkg::ADDR_FIRST_MSB
        && conversion_on_read_select == wtcr_pkg::CONVERSION_ON_READ_SELECT_BEFORE_MSB |=> conv_start_reg ##1 conv_busy_o)
        else $error("read of first MSB did not trigger");

    a_reset_flag_clear: assert property (@(posedge clk_sys_i)
        $rose(arst_n_i) |-> !config_parity_ok_flag_o && !low_power_monitor_enable_o)
        else $error("parity flag set after reset");

    a_bad_parity_off: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        check_pending_reg && !parity_odd && !wake_accept |=> !low_power_monitor_enable_o [*2])
        else $error("monitor left enabled after bad parity");

    a_wake_needs_ok: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $rose(low_power_monitor_enable_o) |-> $past(config_parity_ok_flag_o) && $past(parity_odd))
        else $error("monitor enabled without parity ok");

    a_int_threshold: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        low_power_monitor_enable_o && meas_valid_i && in_alarm ##1 low_power_monitor_enable_o |-> !int_n_o)
        else $error("threshold crossing gave no interrupt");

    a_quad_guard: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $rose(quad_sensitivity_reg) |-> $past(sensor_config_reg[wtcr_pkg::CFG_DOUBLE]))
        else $error("quad set without double");

endmodule // wtcr_regs

// ==== tb/wtcr_host_model.sv ====
`timescale 1ns/10ps
module wtcr_host_model (
    input wire logic clk_i, // Bench clock
    output logic [7:0] reg_addr_o = 8'h00, // Register address
    output logic [7:0] reg_wdata_o = 8'h00, // Write data
    output logic reg_wr_o = 1'h0, // Write strobe
    output logic reg_rd_o = 1'h0, // Read strobe
    input wire logic [7:0] reg_rdata_i // Read data
);
    task automatic acc(input logic [7:0] a, input logic [7:0] wd, input logic w, output logic [7:0] rd);
        @(posedge clk_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = wd;
        {reg_wr_o, reg_rd_o} = {w, ~w};
        @(posedge clk_i);
        #1;
        {reg_wr_o, reg_rd_o} = 2'h0;
        rd = reg_rdata_i;
    endtask
    // legal mode, odd parity given odd Z limits
    task automatic wr_cfg(input logic [7:0] d, input logic bad);
        logic c7;
        logic [7:0] x;
        c7 = d[7] | d[6];
        acc(8'h10, {c7, d[6:1], bad ^ c7 ^ (^d[6:1])}, 1'h1, x);
    endtask
endmodule // wtcr_host_model

// ==== tb/wtcr_regs_tb_top.sv ====
`timescale 1ns/10ps
module wtcr_regs_tb_top;
    logic clk_sys_i = 1'h0, arst_n_i = 1'h0, meas_valid_i = 1'h0, single_byte_read_select_i = 1'h0;
    logic wake_regs_parity_i = 1'h0, reg_wr_i, reg_rd_i, conv_busy_o, int_n_o;
    logic config_parity_ok_flag_o, low_power_monitor_enable_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
    logic [11:0] z_meas_i = 12'h000, adc_data_i = 12'h5A5;
    // Full thresholds become 085 upper and F82 lower with Z limits 2A
    logic [8:0] z_upper_msb_i = 9'h010, z_lower_msb_i = 9'h1F0;
    logic [1:0] adc_channel_o, adc_integ_sel_o, field_temp_coefficient_select_o;
    logic [3:0][11:0] conv_results_o;
    int compares = 0, miscompares = 0, n;
    wtcr_regs dut_u (.*);
    wtcr_host_model host_u (.clk_i(clk_sys_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        miscompares += (seen !== exp);
        if (seen !== exp)
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    endtask
    task automatic test_done(input int extra);
        miscompares += extra;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic meas(input logic [11:0] z, input logic e);
        tick(1);
        z_meas_i = z;
        meas_valid_i = 1'h1;
        tick(1);
        meas_valid_i = 1'h0;
        chk(int_n_o, e);
    endtask
    task automatic run_conv(input logic [7:0] a, input int cyc, input int tcyc);
        int tc = 0;
        host_u.acc(a, 8'h00, 1'h0, d);
        tick(1);
        for (n = 0; conv_busy_o === 1'h1 && n < 5000; n++)
        begin
            chk(adc_integ_sel_o, adc_channel_o === 2'h3 ? 2'h0 : 2'h1);
            tc += (adc_channel_o === 2'h3);
            tick(1);
        end
        if (n == 5000)
            test_done(1);
        chk(12'(n), 12'(cyc));
        chk(12'(tc), 12'(tcyc));
    endtask
    initial
    begin
        tick(8);
        arst_n_i = 1'h1;
        host_u.acc(8'h0F, 8'h00, 1'h0, d);
        chk(d, 8'h38);
        chk(config_parity_ok_flag_o, 1'h0);
        host_u.acc(8'h14, 8'h01, 1'h1, d);
        host_u.acc(8'h14, 8'h00, 1'h0, d);
        chk(d, 8'h00);
        host_u.acc(8'h0F, 8'h2A, 1'h1, d);
        host_u.acc(8'h0F, 8'h00, 1'h0, d);
        chk(d, 8'h2A);
        for (int t = 0; t < 4; t++)
        begin
            host_u.wr_cfg({5'h00, t[1:0], 1'h0}, 1'h0);
            tick(2);
            chk(field_temp_coefficient_select_o, t[1:0]);
            chk(config_parity_ok_flag_o, 1'h1);
        end
        host_u.acc(8'h0D, 8'h40, 1'h1, d);
        tick(2);
        chk(low_power_monitor_enable_o, 1'h1);
        meas(12'h085, 1'h0);
        meas(12'h084, 1'h1);
        meas(12'hF82, 1'h0);
        host_u.wr_cfg(8'h06, 1'h1);
        tick(2);
        chk(config_parity_ok_flag_o, 1'h0);
        chk(low_power_monitor_enable_o, 1'h0);
        host_u.acc(8'h0D, 8'h40, 1'h1, d);
        chk(low_power_monitor_enable_o, 1'h0);
        meas(12'h085, 1'h1);
        host_u.wr_cfg(8'h18, 1'h0);
        host_u.acc(8'h00, 8'h00, 1'h0, d);
        tick(2);
        chk(conv_busy_o, 1'h0);
        single_byte_read_select_i = 1'h1;
        run_conv(8'h00, 6 * wtcr_pkg::FIELD_CYC + wtcr_pkg::TEMP_CYC, wtcr_pkg::TEMP_CYC);
        for (int c = 0; c < 4; c++) chk(conv_results_o[c], 12'h5A5);
        adc_data_i = 12'h3C3;
        host_u.wr_cfg(8'hE8, 1'h0);
        run_conv(8'h05, 4 * wtcr_pkg::FIELD_CYC, 0);
        for (int c = 0; c < 4; c++) chk(conv_results_o[c], c < 2 ? 12'h3C3 : 12'h000);
        host_u.acc(8'h14, 8'h01, 1'h1, d);
        host_u.acc(8'h14, 8'h00, 1'h0, d);
        chk(d, 8'h01);
        wake_regs_parity_i = 1'h1;
        host_u.wr_cfg(8'hE8, 1'h0);
        tick(2);
        chk(config_parity_ok_flag_o, 1'h0);
        host_u.wr_cfg(8'hE8, 1'h1);
        tick(2);
        chk(config_parity_ok_flag_o, 1'h1);
        arst_n_i = 1'h0;
        tick(2);
        arst_n_i = 1'h1;
        chk(config_parity_ok_flag_o, 1'h0);
        host_u.acc(8'h0F, 8'h00, 1'h0, d);
        chk(d, 8'h38);
        test_done(0);
    end
endmodule // wtcr_regs_tb_top
